/* sfe_spi_front.sv */
`timescale 1ns/100ps
`include "sfe_params.svh"

module sfe_spi_front (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic busy_i,
	output logic [7:0] cmd_o,
	output logic cmd_valid_o,
	output logic frame_start_o,
	output logic op_req_o,
	output sfe_pkg::sfe_op_e op_kind_o,
	output logic [`SFE_ADDR_W-1:0] op_addr_o,
	output logic [3:0] op_sector_o,
	output logic [8:0] op_count_o,
	output logic wr_valid_o,
	output logic [`SFE_ADDR_W-1:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	input wire logic wr_ready_i,
	output logic overrun_o,
	output logic standby_o
);
	sfe_stream_if fill ();
	sfe_stream_if drain ();

	sfe_pkg::sfe_state_e state_reg, state_next;
	sfe_pkg::sfe_op_e op_kind_reg, op_kind_next;
	sfe_pkg::sfe_word_s pend_reg, pend_next;
	logic pend_v_reg, pend_v_next;
	logic cs_q_reg, sck_q_reg;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] sh_in_reg, sh_in_next, cmd_reg, cmd_next, so_sh_reg, so_sh_next;
	logic [1:0] addr_cnt_reg, addr_cnt_next;
	logic [`SFE_ADDR_W-1:0] addr_reg, addr_next, op_addr_reg, op_addr_next;
	logic [8:0] dcnt_reg, dcnt_next, op_count_reg, op_count_next;
	logic [3:0] op_sector_reg, op_sector_next;
	logic so_oe_reg, so_oe_next, tx_ready_reg, tx_ready_next, cmd_valid_reg, cmd_valid_next;
	logic frame_start_reg, frame_start_next, op_req_reg, op_req_next;
	logic overrun_reg, overrun_next, standby_reg, standby_next, wait_reg, wait_next;
	logic sck_rise, sck_fall, cs_fall, cs_rise, is_prog;
	logic [7:0] new_byte;

	// sector index of an array address
	function automatic logic [3:0] sector_of(input logic [`SFE_ADDR_W-1:0] a);
		if (a[18:16] != 3'h7) begin
			sector_of = {1'b0, a[18:16]};
		end else if (!a[15]) begin
			sector_of = `SFE_SECT_32K;
		end else if (a[14]) begin
			sector_of = `SFE_SECT_TOP;
		end else if (a[13]) begin
			sector_of = `SFE_SECT_8K_HI;
		end else begin
			sector_of = `SFE_SECT_8K_LO;
		end
	endfunction : sector_of

	assign sck_rise = sck_i & ~sck_q_reg;
	assign sck_fall = ~sck_i & sck_q_reg;
	assign cs_fall = ~cs_n_i & cs_q_reg;
	assign cs_rise = cs_n_i & ~cs_q_reg;
	assign new_byte = {sh_in_reg[6:0], si_i};
	assign is_prog = (cmd_reg == `SFE_OP_PROG_PAGE) || (cmd_reg == `SFE_OP_PROG_SEQ);

	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		sh_in_next = sh_in_reg;
		cmd_next = cmd_reg;
		addr_cnt_next = addr_cnt_reg;
		addr_next = addr_reg;
		dcnt_next = dcnt_reg;
		pend_next = pend_reg;
		pend_v_next = pend_v_reg;
		overrun_next = overrun_reg;
		cmd_valid_next = 1'b0;
		frame_start_next = 1'b0;
		op_req_next = 1'b0;
		op_kind_next = op_kind_reg;
		op_addr_next = op_addr_reg;
		op_sector_next = op_sector_reg;
		op_count_next = op_count_reg;
		if (pend_v_reg && fill.ready) begin
			pend_v_next = 1'b0;
		end
		if (cs_fall) begin
			state_next = sfe_pkg::ST_CMD;
			bit_cnt_next = 3'h0;
			addr_cnt_next = 2'h0;
			dcnt_next = 9'h000;
			overrun_next = 1'b0;
			frame_start_next = 1'b1;
		end else if (cs_rise) begin
			state_next = sfe_pkg::ST_IDLE;
			op_kind_next = sfe_pkg::OP_NONE;
			if (addr_cnt_reg == `SFE_ADDR_BYTES) begin
				unique case (cmd_reg)
					`SFE_OP_ERASE_4K: op_kind_next = sfe_pkg::OP_ERASE_4K;
					`SFE_OP_ERASE_32K: op_kind_next = sfe_pkg::OP_ERASE_32K;
					`SFE_OP_ERASE_64K: op_kind_next = sfe_pkg::OP_ERASE_64K;
					`SFE_OP_PROG_PAGE: op_kind_next = (dcnt_reg != 9'h000) ? sfe_pkg::OP_PROG_PAGE : sfe_pkg::OP_NONE;
					`SFE_OP_PROG_SEQ: op_kind_next = (dcnt_reg != 9'h000) ? sfe_pkg::OP_PROG_SEQ : sfe_pkg::OP_NONE;
					default: op_kind_next = sfe_pkg::OP_NONE;
				endcase
			end
			if (state_reg != sfe_pkg::ST_CMD && cmd_reg == `SFE_OP_ERASE_CHIP) begin
				op_kind_next = sfe_pkg::OP_ERASE_CHIP;
			end
			op_req_next = (op_kind_next != sfe_pkg::OP_NONE) && (state_reg != sfe_pkg::ST_IDLE);
			op_addr_next = addr_reg;
			op_sector_next = sector_of(addr_reg);
			op_count_next = dcnt_reg;
		end else if (!cs_n_i && sck_rise && state_reg != sfe_pkg::ST_IDLE) begin
			sh_in_next = new_byte;
			bit_cnt_next = bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7) begin
				unique case (state_reg)
					sfe_pkg::ST_CMD: begin
						cmd_next = new_byte;
						cmd_valid_next = 1'b1;
						state_next = sfe_pkg::ST_ADDR;
					end
					sfe_pkg::ST_ADDR: begin
						addr_next = {addr_reg[15:0], new_byte};
						addr_cnt_next = addr_cnt_reg + 2'h1;
						if (addr_cnt_reg == 2'h2) begin
							state_next = sfe_pkg::ST_DATA;
						end
					end
					sfe_pkg::ST_DATA: begin
						if (is_prog && pend_v_next) begin
							overrun_next = 1'b1;
						end else if (is_prog) begin
							pend_next.addr = addr_reg;
							pend_next.data = new_byte;
							pend_v_next = 1'b1;
							if (cmd_reg == `SFE_OP_PROG_SEQ) begin
								addr_next = addr_reg + `SFE_ADDR_W'(1);
							end else begin
								addr_next = {addr_reg[`SFE_ADDR_W-1:8], addr_reg[7:0] + 8'h01};
							end
							if (dcnt_reg != `SFE_PAGE_BYTES) begin
								dcnt_next = dcnt_reg + 9'h001;
							end
						end
					end
					default: state_next = sfe_pkg::ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= sfe_pkg::ST_IDLE;
			bit_cnt_reg <= 3'h0;
			sh_in_reg <= 8'h00;
			cmd_reg <= 8'h00;
			addr_cnt_reg <= 2'h0;
			addr_reg <= '0;
			dcnt_reg <= 9'h000;
			pend_reg <= '0;
			pend_v_reg <= 1'b0;
			overrun_reg <= 1'b0;
			cmd_valid_reg <= 1'b0;
			frame_start_reg <= 1'b0;
			op_req_reg <= 1'b0;
			op_kind_reg <= sfe_pkg::OP_NONE;
			op_addr_reg <= '0;
			op_sector_reg <= 4'h0;
			op_count_reg <= 9'h000;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			sh_in_reg <= sh_in_next;
			cmd_reg <= cmd_next;
			addr_cnt_reg <= addr_cnt_next;
			addr_reg <= addr_next;
			dcnt_reg <= dcnt_next;
			pend_reg <= pend_next;
			pend_v_reg <= pend_v_next;
			overrun_reg <= overrun_next;
			cmd_valid_reg <= cmd_valid_next;
			frame_start_reg <= frame_start_next;
			op_req_reg <= op_req_next;
			op_kind_reg <= op_kind_next;
			op_addr_reg <= op_addr_next;
			op_sector_reg <= op_sector_next;
			op_count_reg <= op_count_next;
		end
	end

	// output shifter and power state
	always_comb begin
		so_sh_next = so_sh_reg;
		tx_ready_next = 1'b0;
		so_oe_next = ~cs_n_i;
		wait_next = wait_reg;
		if (!cs_n_i && sck_fall) begin
			if (bit_cnt_reg == 3'h0 && state_reg != sfe_pkg::ST_CMD && state_reg != sfe_pkg::ST_IDLE) begin
				so_sh_next = tx_valid_i ? tx_data_i : `SFE_FILL_BYTE;
				tx_ready_next = tx_valid_i;
			end else begin
				so_sh_next = {so_sh_reg[6:0], 1'b1};
			end
		end
		if (op_req_reg) begin
			wait_next = 1'b1;
		end else if (busy_i) begin
			wait_next = 1'b0;
		end
		standby_next = cs_n_i && !busy_i && !wait_next && !op_req_next;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cs_q_reg <= 1'b1;
			sck_q_reg <= 1'b0;
			so_sh_reg <= `SFE_FILL_BYTE;
			so_oe_reg <= 1'b0;
			tx_ready_reg <= 1'b0;
			wait_reg <= 1'b0;
			standby_reg <= 1'b1;
		end else begin
			cs_q_reg <= cs_n_i;
			sck_q_reg <= sck_i;
			so_sh_reg <= so_sh_next;
			so_oe_reg <= so_oe_next;
			tx_ready_reg <= tx_ready_next;
			wait_reg <= wait_next;
			standby_reg <= standby_next;
		end
	end

	assign fill.valid = pend_v_reg;
	assign fill.word = pend_reg;
	assign drain.ready = wr_ready_i;

	sfe_buf u_buf (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.fill(fill),
		.drain(drain)
	);

	assign so_o = so_sh_reg[7];
	assign so_oe_o = so_oe_reg;
	assign tx_ready_o = tx_ready_reg;
	assign cmd_o = cmd_reg;
	assign cmd_valid_o = cmd_valid_reg;
	assign frame_start_o = frame_start_reg;
	assign op_req_o = op_req_reg;
	assign op_kind_o = op_kind_reg;
	assign op_addr_o = op_addr_reg;
	assign op_sector_o = op_sector_reg;
	assign op_count_o = op_count_reg;
	assign wr_valid_o = drain.valid;
	assign wr_addr_o = drain.word.addr;
	assign wr_data_o = drain.word.data;
	assign overrun_o = overrun_reg;
	assign standby_o = standby_reg;
endmodule : sfe_spi_front

/* sfe_params.svh */
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

`define SFE_ADDR_W 24
`define SFE_OP_ERASE_4K 8'h20
`define SFE_OP_ERASE_32K 8'h52
`define SFE_OP_ERASE_64K 8'hd8
`define SFE_OP_ERASE_CHIP 8'h60
`define SFE_OP_PROG_PAGE 8'h02
`define SFE_OP_PROG_SEQ 8'had
`define SFE_PAGE_BYTES 9'h100
`define SFE_ADDR_BYTES 2'h3
`define SFE_FILL_BYTE 8'hff
`define SFE_SECT_TOP 4'ha
`define SFE_SECT_8K_HI 4'h9
`define SFE_SECT_8K_LO 4'h8
`define SFE_SECT_32K 4'h7
`define SFE_CLK_PERIOD_NS 100

`endif

/* sfe_pkg.sv */
`include "sfe_params.svh"

package sfe_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CMD = 4'h2,
		ST_ADDR = 4'h4,
		ST_DATA = 4'h8
	} sfe_state_e;

	typedef enum logic [6:0] {
		OP_NONE = 7'h01,
		OP_ERASE_4K = 7'h02,
		OP_ERASE_32K = 7'h04,
		OP_ERASE_64K = 7'h08,
		OP_ERASE_CHIP = 7'h10,
		OP_PROG_PAGE = 7'h20,
		OP_PROG_SEQ = 7'h40
	} sfe_op_e;

	typedef struct packed {
		logic [`SFE_ADDR_W-1:0] addr;
		logic [7:0] data;
	} sfe_word_s;
endpackage : sfe_pkg

/* sfe_stream_if.sv */
`timescale 1ns/100ps

interface sfe_stream_if;
	logic valid;
	logic ready;
	sfe_pkg::sfe_word_s word;

	modport src (output valid, output word, input ready);
	modport snk (input valid, input word, output ready);
endinterface : sfe_stream_if

/* sfe_buf.sv */
`timescale 1ns/100ps

// two-entry buffer; fill side ready is low only when both entries hold words
module sfe_buf (
	input wire logic clk_i,
	input wire logic srst_i,
	sfe_stream_if.snk fill,
	sfe_stream_if.src drain
);
	sfe_pkg::sfe_word_s d0_reg, d0_next, d1_reg, d1_next;
	logic v0_reg, v0_next, v1_reg, v1_next;
	logic push, pop;

	assign push = fill.valid & ~v1_reg;
	assign pop = v0_reg & drain.ready;
	assign fill.ready = ~v1_reg;
	assign drain.valid = v0_reg;
	assign drain.word = d0_reg;

	always_comb begin
		d0_next = d0_reg;
		d1_next = d1_reg;
		v0_next = v0_reg;
		v1_next = v1_reg;
		if (pop && v1_reg) begin
			d0_next = d1_reg;
			v0_next = 1'b1;
			v1_next = push;
			if (push) begin
				d1_next = fill.word;
			end
		end else if (pop) begin
			v0_next = push;
			if (push) begin
				d0_next = fill.word;
			end
		end else if (push && !v0_reg) begin
			d0_next = fill.word;
			v0_next = 1'b1;
		end else if (push) begin
			d1_next = fill.word;
			v1_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			d0_reg <= '0;
			d1_reg <= '0;
			v0_reg <= 1'b0;
			v1_reg <= 1'b0;
		end else begin
			d0_reg <= d0_next;
			d1_reg <= d1_next;
			v0_reg <= v0_next;
			v1_reg <= v1_next;
		end
	end
endmodule : sfe_buf

/* sfe_spi_front_monitor.sv */
`timescale 1ns/100ps

module sfe_spi_front_monitor (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic so_o,
	input wire logic so_oe_o,
	input wire logic tx_ready_o,
	input wire logic busy_i,
	input wire logic cmd_valid_o,
	input wire logic frame_start_o,
	input wire logic op_req_o,
	input wire logic wr_valid_o,
	input wire logic [23:0] wr_addr_o,
	input wire logic [7:0] wr_data_o,
	input wire logic wr_ready_i,
	input wire logic standby_o
);
	logic [3:0] fall_reg = 4'h0;
	logic [3:0] rise_reg = 4'h0;

	// recent serial clock edges as seen on the system clock
	always_ff @(posedge clk_i) begin
		fall_reg <= {fall_reg[2:0], $fell(sck_i)};
		rise_reg <= {rise_reg[2:0], $rose(sck_i)};
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	sequence s_sel_fall;
		cs_n_i ##1 !cs_n_i;
	endsequence
	sequence s_desel;
		cs_n_i [*3];
	endsequence

	a_oe_follows_sel: assert property (!$past(srst_i) |-> so_oe_o == !$past(cs_n_i))
		else $error("output enable does not follow select");
	a_so_on_fall: assert property (so_oe_o && $past(so_oe_o) && $changed(so_o) |-> fall_reg != 4'h0)
		else $error("serial output moved without a clock fall");
	a_tx_on_fall: assert property (tx_ready_o |-> fall_reg != 4'h0)
		else $error("read byte loaded without a clock fall");
	a_frame_start: assert property (s_sel_fall |=> frame_start_o)
		else $error("select fall did not start a frame");
	a_desel_quiet: assert property (s_desel |-> !cmd_valid_o && !frame_start_o)
		else $error("activity while deselected");
	a_op_at_end: assert property (op_req_o |-> $past(cs_n_i) && !$past(cs_n_i, 2))
		else $error("operation request without select rise");
	a_busy_standby: assert property (busy_i |=> !standby_o)
		else $error("standby while busy");
	a_req_standby: assert property (op_req_o |-> !standby_o)
		else $error("standby at operation request");
	a_cmd_on_rise: assert property (cmd_valid_o |-> rise_reg != 4'h0)
		else $error("command byte without a clock rise");
	a_wr_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o) && $stable(wr_addr_o))
		else $error("stalled write word changed");
endmodule : sfe_spi_front_monitor

bind sfe_spi_front sfe_spi_front_monitor sfe_spi_front_monitor_inst (.clk_i(clk_i), .srst_i(srst_i),
	.cs_n_i(cs_n_i), .sck_i(sck_i), .so_o(so_o), .so_oe_o(so_oe_o), .tx_ready_o(tx_ready_o), .busy_i(busy_i),
	.cmd_valid_o(cmd_valid_o), .frame_start_o(frame_start_o), .op_req_o(op_req_o), .wr_valid_o(wr_valid_o),
	.wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i), .standby_o(standby_o));

/* sfe_host_model.sv */
`timescale 1ns/100ps

module sfe_host_model (
	input wire logic clk_i,
	input wire logic so_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o
);
	logic idle_hi = 1'b0;

	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
	end

	task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		for (int i = 7; i > 7 - nbits; i--) begin
			sck_o <= 1'b0;
			si_o <= tx[i];
			repeat (3) @(posedge clk_i);
			rx[i] = so_i;
			sck_o <= 1'b1;
			repeat (2) @(posedge clk_i);
		end
	endtask : xfer

	task automatic begin_frame(input logic mode3);
		idle_hi = mode3;
		sck_o <= mode3;
		repeat (2) @(posedge clk_i);
		cs_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask : begin_frame

	task automatic end_frame();
		if (!idle_hi) begin
			sck_o <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
		@(posedge clk_i);
	endtask : end_frame
endmodule : sfe_host_model

/* sfe_spi_front_test.sv */
`timescale 1ns/100ps
`include "sfe_params.svh"

module sfe_spi_front_test;
	typedef struct {
		logic [7:0] cmd;
		logic [23:0] addr;
		int n;
		logic m3;
		sfe_pkg::sfe_op_e kind;
		logic [3:0] sect;
		logic [23:0] last;
	} sfe_row_s;
	sfe_row_s rows [6] = '{
		'{`SFE_OP_ERASE_4K, 24'h07f000, 0, 1'b0, sfe_pkg::OP_ERASE_4K, 4'ha, 24'h0},
		'{`SFE_OP_ERASE_32K, 24'h070000, 0, 1'b1, sfe_pkg::OP_ERASE_32K, 4'h7, 24'h0},
		'{`SFE_OP_ERASE_64K, 24'h010000, 0, 1'b0, sfe_pkg::OP_ERASE_64K, 4'h1, 24'h0},
		'{`SFE_OP_ERASE_CHIP, 24'h07b000, 0, 1'b1, sfe_pkg::OP_ERASE_CHIP, 4'h9, 24'h0},
		'{`SFE_OP_PROG_PAGE, 24'h0780fe, 3, 1'b1, sfe_pkg::OP_PROG_PAGE, 4'h8, 24'h078000},
		'{`SFE_OP_PROG_SEQ, 24'h0780fe, 3, 1'b0, sfe_pkg::OP_PROG_SEQ, 4'h8, 24'h078100}};
	logic clk_i = 1'b0;
	logic srst_i, cs_n_i, sck_i, si_i, so_o, so_oe_o, so_w, tx_valid_i, tx_ready_o, busy_i;
	logic cmd_valid_o, frame_start_o, op_req_o, wr_valid_o, wr_ready_i, overrun_o, standby_o, got;
	logic [7:0] tx_data_i, cmd_o, wr_data_o, rd, last_d;
	logic [23:0] op_addr_o, wr_addr_o, last_a, exp_a;
	logic [3:0] op_sector_o;
	logic [8:0] op_count_o;
	sfe_pkg::sfe_op_e op_kind_o;
	int errors = 0;
	int tests_run = 0;
	int nw = 0;
	int ncmd = 0;
	int ntx = 0;
	int nfs = 0;
	int n0;

	always #50 clk_i = ~clk_i;
	// undriven serial output shows the inverse of its last value
	assign so_w = so_oe_o ? so_o : ~so_o;

	sfe_spi_front sfe_spi_front_inst (.clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
		.si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .busy_i(busy_i), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o),
		.frame_start_o(frame_start_o), .op_req_o(op_req_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
		.op_sector_o(op_sector_o), .op_count_o(op_count_o), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .wr_ready_i(wr_ready_i), .overrun_o(overrun_o), .standby_o(standby_o));
	sfe_host_model sfe_host_model_inst (.clk_i(clk_i), .so_i(so_w), .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i));

	always @(posedge clk_i) begin
		if (cmd_valid_o === 1'b1)
			ncmd++;
		if (tx_ready_o === 1'b1)
			ntx++;
		if (frame_start_o === 1'b1)
			nfs++;
		if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
			nw++;
			last_a = wr_addr_o;
			last_d = wr_data_o;
		end
	end

	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check

	task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input int n, input logic m3);
		logic [7:0] rx;
		sfe_host_model_inst.begin_frame(m3);
		sfe_host_model_inst.xfer(cmd, 8, rx);
		for (int i = 2; i >= 0; i--) begin
			sfe_host_model_inst.xfer(a[8*i +: 8], 8, rx);
			if (i == 1)
				rd = rx;
		end
		for (int i = 0; i < n; i++)
			sfe_host_model_inst.xfer(8'h30 + 8'(i), 8, rx);
		sfe_host_model_inst.end_frame();
		got = 1'b0;
		repeat (8) begin
			@(posedge clk_i);
			if (op_req_o === 1'b1)
				got = 1'b1;
		end
	endtask : frame

	task automatic engine();
		check(standby_o === 1'b0, "standby before busy");
		busy_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		check(standby_o === 1'b0, "standby while busy");
		busy_i <= 1'b0;
		for (int i = 0; i < 8 && standby_o !== 1'b1; i++)
			@(posedge clk_i);
		check(standby_o === 1'b1, "no standby after busy");
	endtask : engine

	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		srst_i = 1'b1;
		tx_data_i = 8'ha5;
		tx_valid_i = 1'b1;
		busy_i = 1'b0;
		wr_ready_i = 1'b1;
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		check(so_oe_o === 1'b0 && standby_o === 1'b1 && op_kind_o === sfe_pkg::OP_NONE, "reset");
		foreach (rows[r]) begin
			n0 = ntx;
			// a program frame reports the address after its last stored byte
			if (rows[r].kind == sfe_pkg::OP_PROG_SEQ)
				exp_a = rows[r].last + 24'h000001;
			else if (rows[r].n > 0)
				exp_a = {rows[r].last[23:8], rows[r].last[7:0] + 8'h01};
			else
				exp_a = rows[r].addr;
			frame(rows[r].cmd, rows[r].addr, rows[r].n, rows[r].m3);
			check(got && op_kind_o === rows[r].kind && op_addr_o === exp_a, "op decode");
			check(cmd_o === rows[r].cmd && ncmd === r + 1 && nfs === r + 1, "command framing");
			check(ntx === n0 + 3 + rows[r].n + (rows[r].m3 ? 0 : 1), "read byte loads");
			check(op_sector_o === rows[r].sect && rd === 8'ha5, "sector or read byte");
			if (rows[r].n > 0)
				check(op_count_o === 9'(rows[r].n) && last_a === rows[r].last && last_d === 8'h32, "program");
			engine();
		end
		n0 = ncmd;
		sfe_host_model_inst.xfer(8'h5a, 8, rd);
		check(ncmd === n0 && so_oe_o === 1'b0, "deselected activity");
		n0 = ntx;
		tx_valid_i <= 1'b0;
		sfe_host_model_inst.begin_frame(1'b0);
		sfe_host_model_inst.xfer(`SFE_OP_ERASE_4K, 8, rd);
		sfe_host_model_inst.xfer(8'h07, 8, rd);
		sfe_host_model_inst.xfer(8'hf0, 8, rd);
		check(rd === `SFE_FILL_BYTE && ntx === n0, "fill byte");
		sfe_host_model_inst.xfer(8'h00, 4, rd);
		// cut the frame inside the last address byte
		sfe_host_model_inst.end_frame();
		repeat (2) @(posedge clk_i);
		check(op_kind_o === sfe_pkg::OP_NONE && standby_o === 1'b1, "cut frame");
		frame(`SFE_OP_ERASE_4K, 24'h004000, 0, 1'b0);
		check(got && op_addr_o === 24'h004000 && op_sector_o === 4'h0, "frame restart");
		engine();
		frame(`SFE_OP_PROG_PAGE, 24'h002000, 0, 1'b1);
		check(got === 1'b0 && op_kind_o === sfe_pkg::OP_NONE && standby_o === 1'b1, "empty program");
		wr_ready_i <= 1'b0;
		n0 = nw;
		frame(`SFE_OP_PROG_PAGE, 24'h001000, 4, 1'b1);
		check(overrun_o === 1'b1 && wr_valid_o === 1'b1 && nw === n0, "stall");
		wr_ready_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		check(nw === n0 + 3 && last_d === 8'h32 && last_a === 24'h001002, "drain");
		engine();
		summarize();
	end
endmodule : sfe_spi_front_test
